// ---- design/tmr_slave_cfg.svh ----
// offsets, field positions, reset values and timing counts for the slave/channel-mode block
`ifndef TMR_SLAVE_CFG_SVH
`define TMR_SLAVE_CFG_SVH
`define OFF_SMC        8'h10
`define OFF_IDE        8'h14
`define OFF_CHM        8'h18
`define OFF_CHEN       8'h20
`define OFF_CMPV       8'h24
`define OFF_CNTV       8'h28
`define OFF_RUN        8'h2C
`define SMC_MASK       32'h0000_0077
`define IDE_MASK       32'h007F_0F0F
`define CHM_MASK       32'h0000_FFFF
`define RST_ZERO       32'h0000_0000
`define F_SMS_LO       4
`define F_TRIGGER_SOURCE_SELECT_LO      0
`define F_CC1SEL_LO    0
`define F_CHAN2_DIRECTION_SELECT_LO    8
`define F_FAST         3
`define F_CLREN        4
`define F_MODE_LO      5
`define F_UPDATE_IRQ_ENABLE         16
`define F_TRIGGER_IRQ_ENABLE         17
`define F_BREAK_IRQ_ENABLE         18
`define F_UPDATE_DMA_ENABLE         19
`define F_COMMUTATION_DMA_ENABLE       20
`define F_TRIGGER_DMA_ENABLE         21
`define F_COMMUTATION_IRQ_ENABLE       22
`define F_CCDEN_LO     8
`define FAST_LAT_NS    60
`define SLOW_LAT_NS    100
`define CLK_PERIOD_NS  20
`define FAST_LAT_CYC   ((`FAST_LAT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOW_LAT_CYC   ((`SLOW_LAT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- design/tmr_slave_pkg.sv ----
// types for the slave/channel-mode block
package tmr_slave_pkg;
  typedef enum logic [2:0] {
    SM_OFF = 3'h0, SM_ENC1 = 3'h1, SM_ENC2 = 3'h2, SM_ENC3 = 3'h3,
    SM_RESET = 3'h4, SM_GATED = 3'h5, SM_TRIG = 3'h6, SM_EXT1 = 3'h7
  } slave_mode_type;
  typedef enum logic [2:0] {
    OM_FROZEN = 3'h0, OM_SET = 3'h1, OM_CLR = 3'h2, OM_TOG = 3'h3,
    OM_LOW = 3'h4, OM_HIGH = 3'h5, OM_PWM1 = 3'h6, OM_PWM2 = 3'h7
  } output_mode_type;
  typedef struct packed {
    logic       commutation;
    logic       brk;
    logic       trigger;
    logic       update;
    logic [3:0] chan;
  } event_type;
  typedef struct packed {
    logic [6:0] irq_unused;
  } spare_type;
endpackage : tmr_slave_pkg

// ---- design/tmr_slave_mode.sv ----
// slave-mode controller, request enable bank and channel 1/2 mode logic with AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "tmr_slave_cfg.svh"
module tmr_slave_mode #(
  parameter int CNT_W = 16
) (
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  input  wire logic [31:0]           s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  input  wire logic [31:0]           s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  output logic [1:0]                 s_axi_bresp_out,
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  input  wire logic [31:0]           s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  output logic [31:0]                s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  output logic                       s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  input  wire logic [3:0]            internal_trigger_line_in,
  input  wire logic                  filtered_input_one_in,
  input  wire logic                  filtered_input_two_in,
  input  wire logic                  filtered_external_trigger_in,
  input  wire logic                  ref_clear_in,
  input  wire tmr_slave_pkg::event_type events_in,
  output logic [7:0]                 irq_req_out,
  output logic [6:0]                 dma_req_out,
  output logic                       chan1_output_reference_out,
  output logic                       chan2_output_reference_out,
  output logic                       shadow_update_out,
  output logic [CNT_W-1:0]           counter_value_out
);
  initial begin
    if (CNT_W < 2 || CNT_W > 32) $error("CNT_W out of range");
  end

  // ------------------------------------------------------------
  // pin synchronisers (three stages, second and third must agree)
  // ------------------------------------------------------------
  logic [8:0] s1, s2, s3, stable, stable_d;
  wire  [8:0] raw = {ref_clear_in, filtered_external_trigger_in, filtered_input_two_in,
                     filtered_input_one_in, internal_trigger_line_in, 1'b0};
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1 <= 9'h000;
      s2 <= 9'h000;
      s3 <= 9'h000;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stable   <= 9'h000;
      stable_d <= 9'h000;
    end else begin
      stable   <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & stable);
      stable_d <= stable;
    end
  end
  wire [3:0] itr_s  = stable[4:1];
  wire       in1    = stable[5];
  wire       in2    = stable[6];
  wire       etr    = stable[7];
  wire       clr_s  = stable[8];
  wire       in1_e  = stable[5] ^ stable_d[5];
  wire       in2_e  = stable[6] ^ stable_d[6];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0]      smc, ide, chm, chen_reg;
  logic [CNT_W-1:0] cmp_val;
  logic             counter_run;
  logic             aw_held, w_held;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             trg_rise;
  tmr_slave_pkg::slave_mode_type mode;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r & msk;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return a == `OFF_SMC || a == `OFF_IDE || a == `OFF_CHM || a == `OFF_CHEN ||
           a == `OFF_CMPV || a == `OFF_CNTV || a == `OFF_RUN;
  endfunction : mapped

  wire do_write = aw_held && w_held && !s_axi_bvalid_out;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= `RST_ZERO;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in[7:0];
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= 2'h0;
    end else begin
      s_axi_awready_out <= !aw_held && !(s_axi_awvalid_in && s_axi_awready_out);
      s_axi_wready_out  <= !w_held && !(s_axi_wvalid_in && s_axi_wready_out);
      if (do_write) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= mapped(aw_addr) ? 2'h0 : 2'h2;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  wire wr_ok = do_write && aw_addr[1:0] == 2'h0;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      smc         <= `RST_ZERO;
      ide         <= `RST_ZERO;
      chm         <= `RST_ZERO;
      chen_reg    <= `RST_ZERO;
      cmp_val     <= '0;
      counter_run <= 1'b0;
    end else begin
      if (wr_ok) begin
        unique case (aw_addr)
          `OFF_SMC:  smc      <= merge(smc, w_data, w_strb, `SMC_MASK);
          `OFF_IDE:  ide      <= merge(ide, w_data, w_strb, `IDE_MASK);
          `OFF_CHM: begin
            chm <= merge(chm, w_data, w_strb, `CHM_MASK);
            if (chen_reg[0]) chm[1:0] <= chm[1:0];
            if (chen_reg[1]) chm[9:8] <= chm[9:8];
          end
          `OFF_CHEN: chen_reg <= merge(chen_reg, w_data, w_strb, 32'h0000_0003);
          `OFF_CMPV: cmp_val  <= CNT_W'(merge({32'h0}, w_data, w_strb, 32'hFFFF_FFFF));
          `OFF_RUN:  counter_run <= w_data[0];
          default: ;
        endcase
      end
      if (trg_rise && mode == tmr_slave_pkg::SM_TRIG) counter_run <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= `RST_ZERO;
      s_axi_rresp_out   <= 2'h0;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out  <= mapped(s_axi_araddr_in[7:0]) ? 2'h0 : 2'h2;
        unique case (s_axi_araddr_in[7:0])
          `OFF_SMC:  s_axi_rdata_out <= smc;
          `OFF_IDE:  s_axi_rdata_out <= ide;
          `OFF_CHM:  s_axi_rdata_out <= chm;
          `OFF_CHEN: s_axi_rdata_out <= chen_reg;
          `OFF_CMPV: s_axi_rdata_out <= 32'(cmp_val);
          `OFF_CNTV: s_axi_rdata_out <= 32'(counter_value_out);
          `OFF_RUN:  s_axi_rdata_out <= {29'h0, chan2_output_reference_out,
                                         chan1_output_reference_out, counter_run};
          default:   s_axi_rdata_out <= `RST_ZERO;
        endcase
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // trigger selection and slave mode
  // ------------------------------------------------------------
  assign mode = tmr_slave_pkg::slave_mode_type'(smc[`F_SMS_LO +: 3]);
  wire [2:0] trigger_source_select = smc[`F_TRIGGER_SOURCE_SELECT_LO +: 3];
  logic trg, trg_d;
  always_comb begin
    unique case (trigger_source_select)
      3'h4:    trg = in1_e;
      3'h5:    trg = in1;
      3'h6:    trg = in2;
      3'h7:    trg = etr;
      default: trg = itr_s[trigger_source_select[1:0]];
    endcase
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) trg_d <= 1'b0;
    else          trg_d <= trg;
  end
  assign trg_rise = trg && !trg_d;

  logic tick, up, reload;
  always_comb begin
    tick   = 1'b0;
    up     = 1'b1;
    reload = 1'b0;
    unique case (mode)
      tmr_slave_pkg::SM_OFF:   tick = counter_run;
      tmr_slave_pkg::SM_ENC1: begin
        tick = counter_run && in1_e;
        up   = in1 ^ in2;
      end
      tmr_slave_pkg::SM_ENC2: begin
        tick = counter_run && in2_e;
        up   = ~(in1 ^ in2);
      end
      tmr_slave_pkg::SM_ENC3: begin
        tick = counter_run && (in1_e || in2_e);
        up   = in1_e ? (in1 ^ in2) : ~(in1 ^ in2);
      end
      tmr_slave_pkg::SM_RESET: begin
        tick   = counter_run;
        reload = trg_rise;
      end
      tmr_slave_pkg::SM_GATED: tick = counter_run && trg;
      tmr_slave_pkg::SM_TRIG:  tick = counter_run;
      tmr_slave_pkg::SM_EXT1:  tick = counter_run && trg_rise;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      counter_value_out <= '0;
      shadow_update_out <= 1'b0;
    end else begin
      shadow_update_out <= reload;
      if (reload)    counter_value_out <= '0;
      else if (tick) counter_value_out <= up ? counter_value_out + 1'b1
                                             : counter_value_out - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // request gating
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_req_out <= 8'h00;
      dma_req_out <= 7'h00;
    end else begin
      irq_req_out <= {events_in.commutation & ide[`F_COMMUTATION_IRQ_ENABLE], events_in.brk & ide[`F_BREAK_IRQ_ENABLE],
                      events_in.trigger & ide[`F_TRIGGER_IRQ_ENABLE], events_in.update & ide[`F_UPDATE_IRQ_ENABLE],
                      events_in.chan & ide[3:0]};
      dma_req_out <= {events_in.trigger & ide[`F_TRIGGER_DMA_ENABLE],
                      events_in.commutation & ide[`F_COMMUTATION_DMA_ENABLE],
                      events_in.update & ide[`F_UPDATE_DMA_ENABLE],
                      events_in.chan & ide[`F_CCDEN_LO +: 4]};
    end
  end

  // ------------------------------------------------------------
  // output reference per channel (fields at offsets 0 and 8)
  // ------------------------------------------------------------
  logic [1:0] ref_q, cmp_lt_d, fast_d;
  logic [2:0] mode_d [2];
  logic [1:0] cap_src;
  assign cap_src[0] = chm[1:0] == 2'h1 ? in1 : chm[1:0] == 2'h2 ? in2 :
                      (chm[1:0] == 2'h3 && !trigger_source_select[2]) ? trg : 1'b0;
  assign cap_src[1] = chm[9:8] == 2'h1 ? in2 : chm[9:8] == 2'h2 ? in1 :
                      (chm[9:8] == 2'h3 && !trigger_source_select[2]) ? trg : 1'b0;

  wire lt    = counter_value_out < cmp_val;
  wire match = counter_value_out == cmp_val;
  for (genvar c = 0; c < 2; c++) begin : g_ch
    wire [7:0] f = chm[c*8 +: 8];
    tmr_slave_pkg::output_mode_type om;
    assign om = tmr_slave_pkg::output_mode_type'(f[`F_MODE_LO +: 3]);
    wire is_out  = f[1:0] == 2'h0;
    wire is_pwm  = om == tmr_slave_pkg::OM_PWM1 || om == tmr_slave_pkg::OM_PWM2;
    wire fast_go = is_pwm && f[`F_FAST] && trg_rise;
    wire pwm_lvl = (om == tmr_slave_pkg::OM_PWM1) ? (lt || fast_go) : (!lt && !fast_go);
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        ref_q[c]    <= 1'b0;
        cmp_lt_d[c] <= 1'b0;
        fast_d[c]   <= 1'b0;
        mode_d[c]   <= 3'h0;
      end else begin
        cmp_lt_d[c] <= lt;
        fast_d[c]   <= fast_go;
        mode_d[c]   <= om;
        if (is_out && f[`F_CLREN] && clr_s) ref_q[c] <= 1'b0;
        else if (is_out) begin
          unique case (om)
            tmr_slave_pkg::OM_FROZEN: ref_q[c] <= ref_q[c];
            tmr_slave_pkg::OM_SET:    if (match) ref_q[c] <= 1'b1;
            tmr_slave_pkg::OM_CLR:    if (match) ref_q[c] <= 1'b0;
            tmr_slave_pkg::OM_TOG:    if (match) ref_q[c] <= ~ref_q[c];
            tmr_slave_pkg::OM_LOW:    ref_q[c] <= 1'b0;
            tmr_slave_pkg::OM_HIGH:   ref_q[c] <= 1'b1;
            default: begin
              if (lt != cmp_lt_d[c] || fast_go || fast_d[c] ||
                  mode_d[c] != 3'(om)) ref_q[c] <= pwm_lvl;
            end
          endcase
        end
      end
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chan1_output_reference_out <= 1'b0;
      chan2_output_reference_out <= 1'b0;
    end else begin
      chan1_output_reference_out <= ref_q[0];
      chan2_output_reference_out <= ref_q[1];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_gate_hold;
    @(posedge clk_in) disable iff (!rstn_in)
      (mode == tmr_slave_pkg::SM_GATED && !trg && !reload) |=> $stable(counter_value_out);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated count moved");
  property p_reset_mode;
    @(posedge clk_in) disable iff (!rstn_in)
      (mode == tmr_slave_pkg::SM_RESET && trg_rise) |=> counter_value_out == '0
        && shadow_update_out;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset mode missed");
  property p_trig_start;
    @(posedge clk_in) disable iff (!rstn_in)
      (mode == tmr_slave_pkg::SM_TRIG && trg_rise) |=> counter_run;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start");
  property p_free_run;
    @(posedge clk_in) disable iff (!rstn_in)
      (mode == tmr_slave_pkg::SM_OFF && counter_run && !wr_ok)
        |=> counter_value_out == $past(counter_value_out) + 1'b1;
  endproperty
  a_free_run: assert property (p_free_run) else $error("no internal tick");
  property p_irq_gate;
    @(posedge clk_in) disable iff (!rstn_in)
      (!ide[`F_UPDATE_IRQ_ENABLE]) |=> !irq_req_out[4];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("update irq not gated");
  property p_dma_gate;
    @(posedge clk_in) disable iff (!rstn_in)
      (events_in.trigger && ide[`F_TRIGGER_DMA_ENABLE]) |=> dma_req_out[6];
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("trigger dma lost");
  property p_sel_lock;
    @(posedge clk_in) disable iff (!rstn_in)
      chen_reg[0] |=> $stable(chm[1:0]);
  endproperty
  a_sel_lock: assert property (p_sel_lock) else $error("locked select changed");
  property p_force_high;
    @(posedge clk_in) disable iff (!rstn_in)
      (chm[1:0] == 2'h0 && chm[7:5] == 3'h5 && !(chm[4] && clr_s)) |=> ##1
        chan1_output_reference_out;
  endproperty
  a_force_high: assert property (p_force_high) else $error("force high failed");
  property p_ref_clear;
    @(posedge clk_in) disable iff (!rstn_in)
      (chm[1:0] == 2'h0 && chm[4] && clr_s) |=> ##1 !chan1_output_reference_out;
  endproperty
  a_ref_clear: assert property (p_ref_clear) else $error("clear ignored");
endmodule : tmr_slave_mode

// ---- sim/trig_source.sv ----
// far-side model: neighbour timer trigger lines and filtered channel inputs
`timescale 1ns/1ns
module trig_source (
  input  wire logic       clk_in,
  output logic [3:0]      itr_out,
  output logic            in_one_out,
  output logic            in_two_out,
  output logic            ext_out,
  output logic            clear_out
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    itr_out = 4'h0;
    in_one_out = 1'b0;
    in_two_out = 1'b0;
    ext_out = 1'b0;
    clear_out = 1'b0;
  end
  // levels change just after an edge, like another timer in this clock domain
  task automatic drive(input logic one, input logic clr);
    in_one_out <= one;
    clear_out <= clr;
  endtask : drive
  // pulses are 6 cycles wide so they survive the input synchroniser
  task automatic pulse_ext(input int n);
    repeat (n) begin
      ext_out <= 1'b1;
      repeat (6) @(posedge clk_in);
      ext_out <= 1'b0;
      repeat (6) @(posedge clk_in);
    end
  endtask : pulse_ext
endmodule : trig_source

// ---- sim/tb_top.sv ----
// self-checking bench for the slave-mode and channel-mode block
`timescale 1ns/1ns
module tb_top;
  logic                     clk_in;
  logic                     rstn_in;
  logic [31:0]              awaddr, wdata, araddr, rdata;
  logic                     awvalid, wvalid, bready, arvalid, rready;
  logic                     awready, wready, bvalid, arready, rvalid;
  logic [1:0]               bresp, rresp;
  logic [3:0]               itr;
  logic                     in_one, in_two, ext, clr, ref1, ref2, shadow;
  tmr_slave_pkg::event_type events;
  logic [7:0]               irq;
  logic [6:0]               dma;
  logic [15:0]              cnt, c0, c1;
  int                       n_fail, cmp_count;
  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  tmr_slave_mode #(.CNT_W(16)) dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .internal_trigger_line_in(itr),
    .filtered_input_one_in(in_one), .filtered_input_two_in(in_two),
    .filtered_external_trigger_in(ext), .ref_clear_in(clr), .events_in(events),
    .irq_req_out(irq), .dma_req_out(dma), .chan1_output_reference_out(ref1),
    .chan2_output_reference_out(ref2), .shadow_update_out(shadow),
    .counter_value_out(cnt));
  trig_source src (.clk_in(clk_in), .itr_out(itr), .in_one_out(in_one),
    .in_two_out(in_two), .ext_out(ext), .clear_out(clr));
  // ----------------------------------------
  // bus tasks and checking
  // ----------------------------------------
  task automatic results;
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // a wait that runs out of its bound ends the run
  task automatic lost(input int k);
    if (k >= 200) begin
      n_fail++;
      $display("wrong value at %0t ns: bus answer timed out", $time);
      results();
    end
  endtask : lost
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    lost(k);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    lost(k);
  endtask : rd
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    events = '0;
    n_fail = 0;
    cmp_count = 0;
    rstn_in = 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd(8'h18, d, r);
    chk(d, 32'h0000_0000);
    rd(8'h30, d, r);
    chk({r, d[29:0]}, 32'h8000_0000);
    // every request source enabled, then a sparse mix
    events <= '1;
    wr(8'h14, 32'h007F_0F0F);
    repeat (3) @(posedge clk_in);
    chk({irq, 1'b0, dma}, 32'h0000_FF7F);
    wr(8'h14, 32'h0055_0005);
    repeat (3) @(posedge clk_in);
    chk({irq, 1'b0, dma}, 32'h0000_D520);
    events <= '0;
    repeat (3) @(posedge clk_in);
    chk({irq, 1'b0, dma}, 32'h0000_0000);
    // forced levels; only channel one honours the clear input
    wr(8'h18, 32'h0000_A0B0);
    repeat (4) @(posedge clk_in);
    chk({ref1, ref2}, 32'h3);
    src.drive(1'b0, 1'b1);
    repeat (8) @(posedge clk_in);
    chk({ref1, ref2}, 32'h1);
    src.drive(1'b0, 1'b0);
    // channel two goes frozen and keeps its high level
    wr(8'h18, 32'h0000_0080);
    repeat (4) @(posedge clk_in);
    chk({ref1, ref2}, 32'h1);
    // selection of an enabled channel must not take
    wr(8'h20, 32'h0000_0001);
    wr(8'h18, 32'h0000_0101);
    rd(8'h18, d, r);
    chk(d, 32'h0000_0100);
    wr(8'h20, 32'h0000_0000);
    // free run on the kernel clock
    wr(8'h10, 32'h0000_0000);
    wr(8'h2C, 32'h0000_0001);
    c0 = cnt;
    repeat (10) @(posedge clk_in);
    chk({16'h0, cnt - c0}, 32'h0000_000A);
    // trigger source set while slave mode is off
    wr(8'h10, 32'h0000_0007);
    wr(8'h10, 32'h0000_0077);
    repeat (6) @(posedge clk_in);
    c0 = cnt;
    src.pulse_ext(5);
    repeat (8) @(posedge clk_in);
    chk({16'h0, cnt - c0}, 32'h0000_0005);
    // gated on input one, never on the edge detector
    wr(8'h10, 32'h0000_0005);
    wr(8'h10, 32'h0000_0055);
    c0 = cnt;
    src.drive(1'b1, 1'b0);
    repeat (20) @(posedge clk_in);
    src.drive(1'b0, 1'b0);
    repeat (10) @(posedge clk_in);
    c1 = cnt;
    repeat (10) @(posedge clk_in);
    chk({16'h0, cnt}, {16'h0, c1});
    chk({31'h0, c1 > c0 + 16'h000A}, 32'h1);
    // trigger mode starts a stopped counter without clearing it
    wr(8'h2C, 32'h0000_0000);
    wr(8'h10, 32'h0000_0005);
    wr(8'h10, 32'h0000_0065);
    c0 = cnt;
    src.drive(1'b1, 1'b0);
    repeat (8) @(posedge clk_in);
    rd(8'h2C, d, r);
    chk({31'h0, d[0]}, 32'h1);
    chk({31'h0, cnt > c0}, 32'h1);
    // reset mode: one shadow pulse and a cleared counter per rising edge
    wr(8'h10, 32'h0000_0005);
    wr(8'h10, 32'h0000_0045);
    src.drive(1'b0, 1'b0);
    repeat (6) @(posedge clk_in);
    c1 = 16'h0000;
    c0 = 16'hFFFF;
    src.drive(1'b1, 1'b0);
    repeat (10) begin
      @(posedge clk_in);
      if (shadow === 1'b1) begin
        c1 = c1 + 16'h0001;
        c0 = cnt;
      end
    end
    chk({16'h0, c1}, 32'h0000_0001);
    chk({16'h0, c0}, 32'h0000_0000);
    results();
  end
endmodule : tb_top
